/* File: logic/dhbc_pkg.sv */
// Constants and types for the dual H-bridge chopper control
// Contract
// - All six inputs low gives standby, Hi-Z.
// - Any input high leaves standby at once.
// - Bridge A decodes stop, CCW and CW.
// - Bridge B decodes the same, independently.
// - Digital blanking is 4 or 6 chop clocks.
// - Blanking starts each charge and select change.
// - Threshold ignored while blanking is active.
// - Fixed analog blanking of about 400 ns added.
// - Pairing low: two bridges; high: one bridge.
// - Large mode follows bridge A inputs; B pins still count for standby and B select changes restart blanking.
// - Blank length applies in both pairing modes.
// - Chopping is timed by the chop oscillator.
// - Charge at counter start; threshold hit gives slow.
// - Slow to fast on the 11th chop edge.
// - After 16 clocks counter resets, charge again.
// - Forward switch pattern per charge, slow, fast.
// - Reverse switch pattern per charge, slow, fast.
package dhbc_pkg;

  // ==========================================================
  // Timing
  localparam int CORE_CLK_MHZ = 10;
  localparam int CHOP_PERIOD_CLKS = 16;
  localparam int FAST_START_EDGE = 11;
  localparam int BLANK_SHORT_CLKS = 4;
  localparam int BLANK_LONG_CLKS = 6;
  localparam int ANALOG_BLANK_NS = 400;
  localparam int ANALOG_BLANK_CYC = (ANALOG_BLANK_NS * CORE_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Counter widths and loads
  localparam int CNT_W = $clog2(CHOP_PERIOD_CLKS);
  localparam int DBLK_W = 3;
  localparam int ABLK_W = $clog2(ANALOG_BLANK_CYC + 1);
  // Restart tick is clock one of a period, so fast decay fills the last six clocks
  localparam logic [CNT_W-1:0] FAST_EDGE_CNT = CNT_W'(FAST_START_EDGE - 2);
  localparam logic [CNT_W-1:0] WRAP_CNT = CNT_W'(CHOP_PERIOD_CLKS - 1);
  localparam logic [DBLK_W-1:0] BLANK_SHORT_CNT = DBLK_W'(BLANK_SHORT_CLKS);
  localparam logic [DBLK_W-1:0] BLANK_LONG_CNT = DBLK_W'(BLANK_LONG_CLKS);
  localparam logic [ABLK_W-1:0] ANALOG_BLANK_CNT = ABLK_W'(ANALOG_BLANK_CYC);

  // ==========================================================
  // Bridges, inputs, switch patterns {UL, UR, LL, LR}
  localparam int NUM_BRIDGES = 2;
  localparam int NUM_SYNC_IN = 11;
  localparam logic [3:0] SW_OFF = 4'h0;
  localparam logic [3:0] SW_LOWERS = 4'h3;
  localparam logic [3:0] SW_UL_LR = 4'h9;
  localparam logic [3:0] SW_UR_LL = 4'h6;
  localparam logic [3:0] SW_RESET = SW_OFF;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    DHBC_CHARGE = 3'h1,
    DHBC_SLOW = 3'h2,
    DHBC_FAST = 3'h4
  } dhbc_phase_t;

  typedef enum logic [3:0] {
    DHBC_OFF = 4'h1,
    DHBC_BRAKE = 4'h2,
    DHBC_CW = 4'h4,
    DHBC_CCW = 4'h8
  } dhbc_cmd_t;

endpackage

/* File: logic/dhbc_chopper.sv */
// Chopping sequencer for one bridge: counter, decay phase, blanking
module dhbc_chopper
  import dhbc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic chopTick,
  input wire logic run,
  input wire logic blankLong,
  input wire logic blankRestart,
  input wire logic thresholdHit,
  // Status
  output dhbc_phase_t phase,
  output logic blankActive
);

  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DBLK_W-1:0] dBlank_reg, dBlank_next;
  logic [ABLK_W-1:0] aBlank_reg, aBlank_next;
  dhbc_phase_t phase_reg, phase_next;

  // ==========================================================
  // Decode
  wire periodEnd = run && chopTick && cnt_reg == WRAP_CNT;
  wire fastEdge = run && chopTick && cnt_reg == FAST_EDGE_CNT;
  // Idle holds both windows armed so the first charge is blanked
  wire restart = !run || periodEnd || blankRestart;
  wire [DBLK_W-1:0] blankLen = blankLong ? BLANK_LONG_CNT : BLANK_SHORT_CNT;
  wire blankDone = dBlank_reg == '0 && aBlank_reg == '0;
  wire senseTrip = chopTick && thresholdHit && blankDone;

  assign cnt_next = !run ? '0 : chopTick ? cnt_reg + 1'b1 : cnt_reg;
  assign dBlank_next = restart ? blankLen :
    (chopTick && dBlank_reg != '0) ? dBlank_reg - 1'b1 : dBlank_reg;
  assign aBlank_next = restart ? ANALOG_BLANK_CNT :
    (aBlank_reg != '0) ? aBlank_reg - 1'b1 : aBlank_reg;

  always_comb begin
    phase_next = phase_reg;
    if (!run || periodEnd) begin
      phase_next = DHBC_CHARGE;
    end else if (fastEdge) begin
      phase_next = DHBC_FAST;
    end else begin
      case (phase_reg)
        DHBC_CHARGE: if (senseTrip) phase_next = DHBC_SLOW;
        default: phase_next = phase_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      dBlank_reg <= BLANK_SHORT_CNT;
      aBlank_reg <= ANALOG_BLANK_CNT;
      phase_reg <= DHBC_CHARGE;
    end else begin
      cnt_reg <= cnt_next;
      dBlank_reg <= dBlank_next;
      aBlank_reg <= aBlank_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
  assign blankActive = !blankDone;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  blank_load_a: assert property (restart |=> dBlank_reg == ($past(blankLong) ? 3'h6 : 3'h4))
    else $error("digital blanking length wrong");
  analog_blank_a: assert property (restart |=> blankActive [*4])
    else $error("analog blanking too short");
  blank_hold_a: assert property (run && phase_reg == DHBC_CHARGE && blankActive
      && !fastEdge && !periodEnd |=> phase_reg == DHBC_CHARGE)
    else $error("threshold acted during blanking");
  slow_entry_a: assert property (run && phase_reg == DHBC_CHARGE && chopTick
      && thresholdHit && !blankActive && !fastEdge && !periodEnd
      |=> phase_reg == DHBC_SLOW)
    else $error("threshold hit did not start slow decay");
  fast_edge_a: assert property (run && chopTick && cnt_reg == 4'h9
      |=> phase_reg == DHBC_FAST)
    else $error("fast decay not on 11th edge");
  period_wrap_a: assert property (run && chopTick && cnt_reg == 4'hF
      |=> phase_reg == DHBC_CHARGE && cnt_reg == 4'h0 && blankActive)
    else $error("period did not restart charge");
  sense_sample_a: assert property (run && phase_reg == DHBC_CHARGE && !chopTick
      && !blankRestart |=> phase_reg == DHBC_CHARGE)
    else $error("threshold taken off chop edge");

  full_period_c: cover property (run && phase_reg == DHBC_SLOW ##[1:1000] phase_reg == DHBC_FAST);
  trip_c: cover property (run && senseTrip);

endmodule

/* File: logic/dhbc_top.sv */
// Dual H-bridge control: input decode, pairing, chopping, switch drive
module dhbc_top
  import dhbc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Bridge A pins
  input wire logic bridgeASelect1,
  input wire logic bridgeASelect2,
  input wire logic bridgeAGate,
  // Bridge B pins
  input wire logic bridgeBSelect1,
  input wire logic bridgeBSelect2,
  input wire logic bridgeBGate,
  // Static configuration pins
  input wire logic blankLengthSelect,
  input wire logic bridgePairingSelect,
  // Chopping oscillator and sense comparators
  input wire logic chopOscillator,
  input wire logic currentThresholdHitA,
  input wire logic currentThresholdHitB,
  // Switch drive, bit 0 bridge A, bit 1 bridge B
  output logic [NUM_BRIDGES-1:0] upperLeftSwitch,
  output logic [NUM_BRIDGES-1:0] upperRightSwitch,
  output logic [NUM_BRIDGES-1:0] lowerLeftSwitch,
  output logic [NUM_BRIDGES-1:0] lowerRightSwitch,
  // Status
  output logic standbyActive
);

  // ==========================================================
  // Input synchronisers
  logic [NUM_SYNC_IN-1:0] syncMeta_reg;
  logic [NUM_SYNC_IN-1:0] syncIn_reg;
  logic chopPrev_reg;
  logic [3:0] selPrev_reg;

  wire [NUM_SYNC_IN-1:0] rawIn = {
    chopOscillator,
    currentThresholdHitB,
    currentThresholdHitA,
    bridgePairingSelect,
    blankLengthSelect,
    bridgeBGate,
    bridgeBSelect2,
    bridgeBSelect1,
    bridgeAGate,
    bridgeASelect2,
    bridgeASelect1
  };

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncMeta_reg <= '0;
      syncIn_reg <= '0;
    end else begin
      syncMeta_reg <= rawIn;
      syncIn_reg <= syncMeta_reg;
    end
  end

  // ==========================================================
  // Named synchronised inputs
  wire aSel1 = syncIn_reg[0];
  wire aSel2 = syncIn_reg[1];
  wire aGate = syncIn_reg[2];
  wire bSel1 = syncIn_reg[3];
  wire bSel2 = syncIn_reg[4];
  wire bGate = syncIn_reg[5];
  wire blankLong = syncIn_reg[6];
  // Pairing is strapped; a change in operation is not recovered cleanly
  wire paired = syncIn_reg[7];
  wire hitA = syncIn_reg[8];
  wire hitB = syncIn_reg[9];
  wire chopSync = syncIn_reg[10];

  wire [3:0] selNow = {bSel2, bSel1, aSel2, aSel1};

  // ==========================================================
  // Chop clock edge and select change detection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chopPrev_reg <= 1'b0;
      selPrev_reg <= 4'h0;
    end else begin
      chopPrev_reg <= chopSync;
      selPrev_reg <= selNow;
    end
  end

  // Oscillator rate is far below core_clk, so one enable per edge
  wire chopTick = chopSync && !chopPrev_reg;
  wire selChange = |(selNow ^ selPrev_reg);

  // ==========================================================
  // Standby
  wire allLow = !(aSel1 || aSel2 || aGate || bSel1 || bSel2 || bGate);

  // ==========================================================
  // Per-bridge pins gathered for the generate loop
  wire [NUM_BRIDGES-1:0] gateIn = {bGate, aGate};
  wire [NUM_BRIDGES-1:0] sel1In = {bSel1, aSel1};
  wire [NUM_BRIDGES-1:0] sel2In = {bSel2, aSel2};
  wire [NUM_BRIDGES-1:0] hitIn = {hitB, hitA};

  dhbc_cmd_t cmd [NUM_BRIDGES];
  dhbc_phase_t phase [NUM_BRIDGES];
  logic [NUM_BRIDGES-1:0] blankBusy;
  logic [3:0] swRaw [NUM_BRIDGES];
  logic [3:0] swNext [NUM_BRIDGES];
  logic [3:0] sw_reg [NUM_BRIDGES];

  genvar b;
  generate
    for (b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
      wire gt = gateIn[b];
      wire s1 = sel1In[b];
      wire s2 = sel2In[b];
      wire isStop = gt && !s1 && !s2;
      wire isCw = gt && s1 && !s2;
      wire isCcw = gt && !s1 && s2;
      wire isOff = isStop || allLow;
      wire isRun = (isCw || isCcw) && !allLow;
      wire [3:0] chargeSw = isCw ? SW_UL_LR : SW_UR_LL;
      wire [3:0] fastSw = isCw ? SW_UR_LL : SW_UL_LR;

      // Brake covers gate low outside standby, whatever the selects, and both selects high
      assign cmd[b] = isOff ? DHBC_OFF : isCw ? DHBC_CW :
        isCcw ? DHBC_CCW : DHBC_BRAKE;

      // Blank length shared by both bridges in either pairing mode
      dhbc_chopper u_chopper (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .chopTick(chopTick),
        .run(isRun),
        .blankLong(blankLong),
        .blankRestart(selChange),
        .thresholdHit(hitIn[b]),
        .phase(phase[b]),
        .blankActive(blankBusy[b])
      );

      assign swRaw[b] = (cmd[b] == DHBC_OFF) ? SW_OFF :
        (cmd[b] == DHBC_BRAKE) ? SW_LOWERS :
        (phase[b] == DHBC_SLOW) ? SW_LOWERS :
        (phase[b] == DHBC_FAST) ? fastSw : chargeSw;

      // Large mode: bridge B mirrors bridge A; its pins still count for standby and its select changes restart blanking
      if (b == 0) begin : g_own
        assign swNext[b] = swRaw[b];
      end else begin : g_pair
        assign swNext[b] = paired ? swRaw[0] : swRaw[b];
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          sw_reg[b] <= SW_RESET;
        end else begin
          sw_reg[b] <= swNext[b];
        end
      end

      assign upperLeftSwitch[b] = sw_reg[b][3];
      assign upperRightSwitch[b] = sw_reg[b][2];
      assign lowerLeftSwitch[b] = sw_reg[b][1];
      assign lowerRightSwitch[b] = sw_reg[b][0];
    end
  endgenerate

  // ==========================================================
  // Standby flag
  logic standby_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_reg <= 1'b1;
    end else begin
      standby_reg <= allLow;
    end
  end

  assign standbyActive = standby_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  wire [3:0] swA = sw_reg[0];
  wire [3:0] swB = sw_reg[1];

  standby_off_a: assert property (allLow |=> standbyActive && swA == 4'h0
      && swB == 4'h0)
    else $error("standby did not switch all outputs off");

  standby_exit_a: assert property (standbyActive && !allLow |=> !standbyActive)
    else $error("standby not left after an input rose");

  stop_a_a: assert property (aGate && !aSel1 && !aSel2 && !paired
      |=> swA == 4'h0 && swB == $past(swRaw[1]))
    else $error("bridge A stop not Hi-Z");

  cw_a_a: assert property (aGate && aSel1 && !aSel2 && phase[0] == DHBC_CHARGE
      |=> upperLeftSwitch[0] && lowerRightSwitch[0] && !upperRightSwitch[0]
      && !lowerLeftSwitch[0])
    else $error("bridge A clockwise charge pattern wrong");

  ccw_a_a: assert property (aGate && !aSel1 && aSel2 && phase[0] == DHBC_CHARGE
      |=> upperRightSwitch[0] && lowerLeftSwitch[0] && !upperLeftSwitch[0]
      && !lowerRightSwitch[0])
    else $error("bridge A counter-clockwise charge pattern wrong");

  brake_b_a: assert property (!paired && !bGate && (bSel1 || bSel2)
      |=> swB == 4'h3)
    else $error("bridge B brake pattern wrong");

  brake_both_a: assert property (aSel1 && aSel2 |=> swA == 4'h3)
    else $error("both selects high did not brake");

  pair_mirror_a: assert property (paired && $past(paired) |-> swB == swA)
    else $error("large mode bridges differ");

  pair_ignore_a: assert property (paired && aGate && aSel1 && !aSel2 && !bSel1
      && phase[0] == DHBC_CHARGE |=> swB == 4'h9)
    else $error("bridge B pins acted in large mode");

  fwd_fast_a: assert property (aGate && aSel1 && !aSel2 && phase[0] == DHBC_FAST
      |=> swA == 4'h6)
    else $error("forward fast decay pattern wrong");

  rev_fast_a: assert property (aGate && !aSel1 && aSel2 && phase[0] == DHBC_FAST
      |=> swA == 4'h9)
    else $error("reverse fast decay pattern wrong");

  slow_dec_a: assert property (aGate && (aSel1 ^ aSel2)
      && phase[0] == DHBC_SLOW |=> swA == 4'h3)
    else $error("slow decay pattern wrong");

  no_shoot_a: assert property (!(upperLeftSwitch[0] && lowerLeftSwitch[0])
      && !(upperRightSwitch[0] && lowerRightSwitch[0]))
    else $error("bridge A leg shoot-through");

  sel_blank_a: assert property (selChange && !allLow |=> blankBusy[0] [*4])
    else $error("select change did not blank");

  chop_tick_a: assert property (chopTick |=> !chopTick)
    else $error("chop tick longer than one cycle");

  standby_c: cover property (standbyActive ##1 !standbyActive);
  cw_chop_c: cover property (swA == 4'h9 ##[1:1000] swA == 4'h3 ##[1:1000] swA == 4'h6);
  paired_c: cover property (paired && swB == 4'h9);

endmodule

/* File: testbench/dhbc_host_model.sv */
// Far-side model: free-running chop oscillator and per-bridge current comparators
module dhbc_host_model
  import dhbc_pkg::*;
#(
  parameter int OSC_HALF_NS = 400,
  parameter int RISE_CYCLES = 3
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Test control
  input wire logic loadOn,
  // Switch state of both bridges
  input wire logic [NUM_BRIDGES-1:0] upperLeftSwitch,
  input wire logic [NUM_BRIDGES-1:0] upperRightSwitch,
  input wire logic [NUM_BRIDGES-1:0] lowerLeftSwitch,
  input wire logic [NUM_BRIDGES-1:0] lowerRightSwitch,
  // Device inputs
  output logic chopOscillator,
  output logic [NUM_BRIDGES-1:0] thresholdHit
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [NUM_BRIDGES-1:0] charging;
  logic [7:0] chargeCnt [NUM_BRIDGES];

  // ==========================================================
  // Oscillator
  // Offset start keeps the chop edges off the core_clk edges
  initial begin
    chopOscillator = 1'b0;
    #130;
    forever #(OSC_HALF_NS) chopOscillator = ~chopOscillator;
  end

  // ==========================================================
  // Comparators
  // Current only climbs while a diagonal pair conducts
  assign charging = (upperLeftSwitch & lowerRightSwitch) | (upperRightSwitch & lowerLeftSwitch);

  always_ff @(posedge core_clk or negedge arst_n) begin
    for (int i = 0; i < NUM_BRIDGES; i++) begin
      if (!arst_n) begin
        chargeCnt[i] <= 8'h00;
        thresholdHit[i] <= 1'b0;
      end else begin
        chargeCnt[i] <= charging[i] ? chargeCnt[i] + 8'h01 : 8'h00;
        thresholdHit[i] <= loadOn && charging[i] && (chargeCnt[i] >= 8'(RISE_CYCLES));
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the dual H-bridge chopper control
module tb_top
  import dhbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk, arst_n, loadOn;
  logic bridgeASelect1, bridgeASelect2, bridgeAGate;
  logic bridgeBSelect1, bridgeBSelect2, bridgeBGate;
  logic blankLengthSelect, bridgePairingSelect, chopOscillator, standbyActive;
  logic [NUM_BRIDGES-1:0] hitVec, upperLeftSwitch, upperRightSwitch;
  logic [NUM_BRIDGES-1:0] lowerLeftSwitch, lowerRightSwitch;
  logic [7:0] nc, ns, nf, chargeShort;
  int err_total = 0;
  int checks_done = 0;

  dhbc_top i_dut (
    .core_clk(core_clk), .arst_n(arst_n),
    .bridgeASelect1(bridgeASelect1), .bridgeASelect2(bridgeASelect2),
    .bridgeAGate(bridgeAGate), .bridgeBSelect1(bridgeBSelect1),
    .bridgeBSelect2(bridgeBSelect2), .bridgeBGate(bridgeBGate),
    .blankLengthSelect(blankLengthSelect), .bridgePairingSelect(bridgePairingSelect),
    .chopOscillator(chopOscillator), .currentThresholdHitA(hitVec[0]),
    .currentThresholdHitB(hitVec[1]), .upperLeftSwitch(upperLeftSwitch),
    .upperRightSwitch(upperRightSwitch), .lowerLeftSwitch(lowerLeftSwitch),
    .lowerRightSwitch(lowerRightSwitch), .standbyActive(standbyActive)
  );

  dhbc_host_model i_host (
    .core_clk(core_clk), .arst_n(arst_n), .loadOn(loadOn),
    .upperLeftSwitch(upperLeftSwitch), .upperRightSwitch(upperRightSwitch),
    .lowerLeftSwitch(lowerLeftSwitch), .lowerRightSwitch(lowerRightSwitch),
    .chopOscillator(chopOscillator), .thresholdHit(hitVec)
  );

  // ==========================================================
  // Helpers
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [3:0] pat(input int i);
    return {upperLeftSwitch[i], upperRightSwitch[i], lowerLeftSwitch[i], lowerRightSwitch[i]};
  endfunction

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen %0h expected %0h", $time, seen, want);
    end
  endtask

  // Pin triples are {gate, select1, select2}
  task automatic set_pins(input logic [2:0] a, input logic [2:0] b);
    @(posedge core_clk);
    {bridgeAGate, bridgeASelect1, bridgeASelect2} <= a;
    {bridgeBGate, bridgeBSelect1, bridgeBSelect2} <= b;
  endtask

  // Two sync stages plus the output register, then a margin edge
  task automatic settle();
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Straps only move while reset is held
  task automatic do_reset(input logic pair, input logic blank);
    @(posedge core_clk);
    arst_n <= 1'b0;
    bridgePairingSelect <= pair;
    blankLengthSelect <= blank;
    {bridgeAGate, bridgeASelect1, bridgeASelect2} <= 3'b000;
    {bridgeBGate, bridgeBSelect1, bridgeBSelect2} <= 3'b000;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
  endtask

  // Cycle counts of charge, slow and fast over one whole chop period
  task automatic measure(input int br, input logic [3:0] chg, input logic [3:0] fst);
    int guard;
    guard = 0;
    nc = 8'h00;
    ns = 8'h00;
    nf = 8'h00;
    @(negedge core_clk);
    // First period after a start may be partial, so skip it
    while (pat(br) !== fst && guard < 800) begin @(negedge core_clk); guard++; end
    while (pat(br) === fst && guard < 800) begin @(negedge core_clk); guard++; end
    while (pat(br) === chg && guard < 800) begin nc++; @(negedge core_clk); guard++; end
    while (pat(br) === SW_LOWERS && guard < 800) begin ns++; @(negedge core_clk); guard++; end
    while (pat(br) === fst && guard < 800) begin nf++; @(negedge core_clk); guard++; end
    if (guard >= 800) begin
      err_total++;
      $display("[ERR] t=%0t chop period not seen", $time);
      close_out();
    end
  endtask

  function automatic logic [3:0] decode(input logic [2:0] c);
    case (c)
      3'b100: return SW_OFF;
      3'b110: return SW_UL_LR;
      3'b101: return SW_UR_LL;
      default: return SW_LOWERS;
    endcase
  endfunction

  // ==========================================================
  // Sequence
  initial begin
    arst_n = 1'b0;
    loadOn = 1'b0;
    {bridgeAGate, bridgeASelect1, bridgeASelect2} = 3'b000;
    {bridgeBGate, bridgeBSelect1, bridgeBSelect2} = 3'b000;
    blankLengthSelect = 1'b0;
    bridgePairingSelect = 1'b0;
    do_reset(1'b0, 1'b0);
    settle();
    check(8'(standbyActive), 8'h01);
    check(8'({pat(1), pat(0)}), 8'h00);
    for (int p = 0; p < 6; p++) begin
      set_pins(3'(6'h01 << p), 3'(6'h01 << p >> 3));
      settle();
      check(8'(standbyActive), 8'h00);
      set_pins(3'b000, 3'b000);
      settle();
      check(8'(standbyActive), 8'h01);
      check(8'({pat(1), pat(0)}), 8'h00);
    end
    for (int br = 0; br < 2; br++) begin
      for (int c = 1; c < 8; c++) begin
        set_pins(3'b100, 3'b100);
        settle();
        if (br == 0) set_pins(3'(c), 3'b100);
        else set_pins(3'b100, 3'(c));
        settle();
        check(8'(pat(br)), 8'(decode(3'(c))));
        check(8'(pat(1 - br)), 8'(SW_OFF));
      end
    end
    // No threshold: charge runs to the fast edge
    set_pins(3'b110, 3'b101);
    measure(0, SW_UL_LR, SW_UR_LL);
    check(nc, 8'd80);
    check(ns, 8'h00);
    check(nf, 8'd48);
    measure(1, SW_UR_LL, SW_UL_LR);
    check(nc, 8'd80);
    check(nf, 8'd48);
    // Comparator trips early in charge
    loadOn <= 1'b1;
    measure(0, SW_UL_LR, SW_UR_LL);
    chargeShort = nc;
    check(8'(ns > 8'h00), 8'h01);
    check(nc + ns + nf, 8'd128);
    check(nf, 8'd48);
    // Paired mode, long blanking, B pins deliberately active
    do_reset(1'b1, 1'b1);
    set_pins(3'b110, 3'b101);
    measure(0, SW_UL_LR, SW_UR_LL);
    check(nc - chargeShort, 8'd16);
    check(nf, 8'd48);
    check(8'(pat(1)), 8'(SW_UL_LR));
    // Separate bridges, long blanking, bridge B comparator live
    do_reset(1'b0, 1'b1);
    set_pins(3'b110, 3'b101);
    measure(1, SW_UR_LL, SW_UL_LR);
    check(nc, 8'd56);
    check(nf, 8'd48);
    check(8'(ns > 8'h00), 8'h01);
    close_out();
  end
endmodule
